// file: rtl/sfr_low_pkg.sv
// Constants and register map of the low special function register bank
// What this block does
// - Stack pointer holds a scratchpad address and always marks the stack top.
// - Low byte at 82h and high byte at 83h form one 16-bit data pointer.
// - Port option bit 0 clear gives open-drain port 0, set gives pull-ups.
// - Power control bit 7 doubles serial baud rate in modes 1, 2, 3.
// - Power control bit 6 turns serial control bit 7 into framing error flag.
// - Power control bit 4 is set by power-on reset, cleared by software.
// - Writing one to power control bit 1 enters power-down mode.
// - Writing one to power control bit 0 enters idle mode.
// - Timer 1 overflow flag set on overflow, cleared on service, software writable.
// - Timer 0 overflow flag set on overflow, cleared on service, software writable.
// - Timer control bit 6 runs timer 1 when set, stops it when clear.
// - Timer control bit 4 runs timer 0 when set, stops it when clear.
// - Interrupt 1 pending set by falling edge or low level; edge clears on service.
// - Interrupt 0 pending set by falling edge or low level; edge clears on service.
// - Timer control bit 2 selects falling edge or low level for interrupt 1.
// - Timer control bit 0 selects falling edge or low level for interrupt 0.
// - Reset loads stack pointer 07h, clears the rest, keeps the power-on flag.
// - Idle stops processor clock only; any interrupt or reset leaves idle.
// - Power-down stops all clocks; reset or enabled external interrupt leaves it.
package sfr_low_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_SP = 10'h081;
    localparam logic [IDX_W-1:0] IDX_DPL = 10'h082;
    localparam logic [IDX_W-1:0] IDX_DPH = 10'h083;
    localparam logic [IDX_W-1:0] IDX_CAL = 10'h084;
    localparam logic [IDX_W-1:0] IDX_CAH = 10'h085;
    localparam logic [IDX_W-1:0] IDX_PORT_OPTION = 10'h086;
    localparam logic [IDX_W-1:0] IDX_POWER_CONTROL = 10'h087;
    localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL = 10'h088;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int PORT_OPTION_PULLUP = 0;
    localparam int POWER_CONTROL_BAUD_DOUBLER = 7;
    localparam int POWER_CONTROL_FRAMING_ERROR_SELECT = 6;
    localparam int POWER_CONTROL_POF = 4;
    localparam int POWER_CONTROL_GF1 = 3;
    localparam int POWER_CONTROL_GF0 = 2;
    localparam int POWER_CONTROL_PD = 1;
    localparam int POWER_CONTROL_IDL = 0;
    localparam int TIMER_CONTROL_TF1 = 7;
    localparam int TIMER_CONTROL_TR1 = 6;
    localparam int TIMER_CONTROL_TF0 = 5;
    localparam int TIMER_CONTROL_TR0 = 4;
    localparam int TIMER_CONTROL_IE1 = 3;
    localparam int TIMER_CONTROL_IT1 = 2;
    localparam int TIMER_CONTROL_IE0 = 1;
    localparam int TIMER_CONTROL_IT0 = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        PM_RUN = 3'h1,
        PM_IDLE = 3'h2,
        PM_DOWN = 3'h4
    } power_mode_e;
endpackage

// file: rtl/ext_irq_if.sv
// Link between the register bank and one external interrupt detector
interface ext_irq_if;
    logic edge_sel;
    logic sw_we;
    logic sw_val;
    logic isr_ack;
    logic pending;
    logic pin_low;
    modport detector (input edge_sel, input sw_we, input sw_val,
        input isr_ack, output pending, output pin_low);
    modport bank (output edge_sel, output sw_we, output sw_val,
        output isr_ack, input pending, input pin_low);
endinterface

// file: rtl/ext_irq_detect.sv
// External interrupt pin synchroniser with edge or level pending flag
module ext_irq_detect
    import sfr_low_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    ext_irq_if.detector irq
);
    logic s1_r;
    logic s2_r;
    logic prev_r;
    logic pend_r;
    logic pend_low_r;
    logic pend_nxt;
    wire fall = prev_r & ~s2_r;
    // Level mode follows the pin; in edge mode a new edge beats the clear
    assign pend_nxt = !irq.edge_sel ? ~s2_r :
                      fall ? 1'b1 :
                      irq.isr_ack ? 1'b0 :
                      irq.sw_we ? irq.sw_val : pend_r;
    // Idle high so that leaving reset never fakes an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            prev_r <= 1'b1;
            pend_r <= 1'b0;
            pend_low_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            prev_r <= s2_r;
            pend_r <= pend_nxt;
            pend_low_r <= ~s2_r;
        end
    end
    assign irq.pending = pend_r;
    assign irq.pin_low = pend_low_r;
    edge_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq.edge_sel && fall |=> irq.pending)
        else $error("edge did not set pending");
    level_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !irq.edge_sel |=> irq.pending == !$past(s2_r))
        else $error("level pending does not follow pin");
    edge_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq.edge_sel && !fall && irq.isr_ack |=> !irq.pending)
        else $error("service entry did not clear edge pending");
endmodule // ext_irq_detect

// file: rtl/power_mode_ctrl.sv
// Idle and power-down sequencing with clock enables
module power_mode_ctrl
    import sfr_low_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic idle_req,
    input wire logic pd_req,
    input wire logic wake_any,
    input wire logic wake_ext,
    output logic idle_mode,
    output logic pd_mode,
    output logic cpu_clock_enable,
    output logic osc_enable
);
    power_mode_e state_r;
    power_mode_e state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PM_RUN: begin
                // Power-down wins when both bits are written together
                if (pd_req) state_nxt = PM_DOWN;
                else if (idle_req) state_nxt = PM_IDLE;
            end
            PM_IDLE: if (wake_any || wake_ext) state_nxt = PM_RUN;
            PM_DOWN: if (wake_ext) state_nxt = PM_RUN;
            default: state_nxt = PM_RUN;
        endcase
    end
    // This logic sits on the always-on clock so it can still see a wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PM_RUN;
            cpu_clock_enable <= 1'b1;
            osc_enable <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cpu_clock_enable <= state_nxt == PM_RUN;
            osc_enable <= state_nxt != PM_DOWN;
        end
    end
    assign idle_mode = state_r == PM_IDLE;
    assign pd_mode = state_r == PM_DOWN;
    pd_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == PM_RUN && pd_req |=> !osc_enable && !cpu_clock_enable)
        else $error("power-down did not stop clocks");
    idle_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == PM_RUN && idle_req && !pd_req
        |=> !cpu_clock_enable && osc_enable)
        else $error("idle did not stop processor clock only");
    pd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == PM_DOWN && !wake_ext |=> !osc_enable)
        else $error("power-down left without external wake");
endmodule // power_mode_ctrl

// file: rtl/core_sfr_low_bank.sv
// Low special function register bank behind an AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
module core_sfr_low_bank
    import sfr_low_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_on_reset,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic ext_irq0_enable,
    input wire logic ext_irq1_enable,
    input wire logic irq_wake,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer0_isr_ack,
    input wire logic timer1_isr_ack,
    input wire logic ext_irq0_isr_ack,
    input wire logic ext_irq1_isr_ack,
    input wire logic stack_push,
    input wire logic stack_pop,
    output logic [7:0] stack_top_pointer,
    output logic [15:0] data_pointer,
    output logic [15:0] port4_0_compare_addr,
    output logic port0_pullup_enable,
    output logic baud_doubler,
    output logic framing_error_select,
    output logic timer1_run,
    output logic timer0_run,
    output logic timer1_overflow_flag,
    output logic timer0_overflow_flag,
    output logic ext_irq1_pending,
    output logic ext_irq0_pending,
    output logic cpu_clock_enable,
    output logic osc_enable
);
    ext_irq_if irq0 ();
    ext_irq_if irq1 ();

    logic awready_r;
    logic wready_r;
    logic arready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    logic [7:0] sp_r;
    logic [7:0] sp_nxt;
    logic [7:0] dpl_r;
    logic [7:0] dph_r;
    logic [7:0] cal_r;
    logic [7:0] cah_r;
    logic port_option_r;
    logic baud_doubler_r;
    logic framing_error_select_r;
    logic pof_r;
    logic gf1_r;
    logic gf0_r;
    logic tf1_r;
    logic tf1_nxt;
    logic tf0_r;
    logic tf0_nxt;
    logic tr1_r;
    logic tr0_r;
    logic it1_r;
    logic it0_r;
    logic por_s1_r;
    logic por_s2_r;
    logic idle_mode;
    logic pd_mode;

    wire aw_hs = s_axi_awvalid & awready_r;
    wire w_hs = s_axi_wvalid & wready_r;
    wire ar_hs = s_axi_arvalid & arready_r;
    wire b_done = bvalid_r & s_axi_bready;
    wire r_done = rvalid_r & s_axi_rready;

    // Write decode: both halves held, response not yet out
    wire do_write = aw_held_r & w_held_r & ~bvalid_r;
    wire [IDX_W-1:0] widx = waddr_r[ADDR_W-1:2];
    wire waligned = waddr_r[1:0] == 2'h0;
    wire wmapped = waligned && widx >= IDX_SP && widx <= IDX_TIMER_CONTROL;
    wire wen = do_write & wlane_r & waligned;
    wire wr_sp = wen && widx == IDX_SP;
    wire wr_dpl = wen && widx == IDX_DPL;
    wire wr_dph = wen && widx == IDX_DPH;
    wire wr_cal = wen && widx == IDX_CAL;
    wire wr_cah = wen && widx == IDX_CAH;
    wire wr_port_option = wen && widx == IDX_PORT_OPTION;
    wire wr_power_control = wen && widx == IDX_POWER_CONTROL;
    wire wr_timer_control = wen && widx == IDX_TIMER_CONTROL;

    // Read decode
    wire [IDX_W-1:0] ridx = s_axi_araddr[ADDR_W-1:2];
    wire raligned = s_axi_araddr[1:0] == 2'h0;
    wire rmapped = raligned && ridx >= IDX_SP && ridx <= IDX_TIMER_CONTROL;
    // Reserved bits are simply not stored, so they read zero
    wire [7:0] port_option_byte = {7'h00, port_option_r};
    wire [7:0] power_control_byte = {baud_doubler_r, framing_error_select_r, 1'b0, pof_r,
                            gf1_r, gf0_r, pd_mode, idle_mode};
    wire [7:0] timer_control_byte = {tf1_r, tr1_r, tf0_r, tr0_r,
                            irq1.pending, it1_r, irq0.pending, it0_r};
    wire [7:0] rd_byte = !rmapped ? BYTE_RESET :
                         ridx == IDX_SP ? sp_r :
                         ridx == IDX_DPL ? dpl_r :
                         ridx == IDX_DPH ? dph_r :
                         ridx == IDX_CAL ? cal_r :
                         ridx == IDX_CAH ? cah_r :
                         ridx == IDX_PORT_OPTION ? port_option_byte :
                         ridx == IDX_POWER_CONTROL ? power_control_byte : timer_control_byte;

    // Write channels: each side is taken once, freed with the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
            waddr_r <= '0;
        end else if (aw_hs) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
        end else if (b_done) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
            wbyte_r <= BYTE_RESET;
            wlane_r <= 1'b0;
        end else if (w_hs) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
        end else if (b_done) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wmapped ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read channel: one outstanding read, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rmapped ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= {24'h00_0000, rd_byte};
        end else if (r_done) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Stack pointer: a bus write beats a push or pop in the same cycle
    assign sp_nxt = wr_sp ? wbyte_r :
                    stack_push ? 8'(sp_r + 8'h01) :
                    stack_pop ? 8'(sp_r - 8'h01) : sp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_r <= SP_RESET;
            dpl_r <= BYTE_RESET;
            dph_r <= BYTE_RESET;
            cal_r <= BYTE_RESET;
            cah_r <= BYTE_RESET;
        end else begin
            sp_r <= sp_nxt;
            if (wr_dpl) dpl_r <= wbyte_r;
            if (wr_dph) dph_r <= wbyte_r;
            if (wr_cal) cal_r <= wbyte_r;
            if (wr_cah) cah_r <= wbyte_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_option_r <= 1'b0;
            baud_doubler_r <= 1'b0;
            framing_error_select_r <= 1'b0;
            gf1_r <= 1'b0;
            gf0_r <= 1'b0;
        end else begin
            if (wr_port_option) port_option_r <= wbyte_r[PORT_OPTION_PULLUP];
            if (wr_power_control) begin
                baud_doubler_r <= wbyte_r[POWER_CONTROL_BAUD_DOUBLER];
                framing_error_select_r <= wbyte_r[POWER_CONTROL_FRAMING_ERROR_SELECT];
                gf1_r <= wbyte_r[POWER_CONTROL_GF1];
                gf0_r <= wbyte_r[POWER_CONTROL_GF0];
            end
        end
    end

    // The power-on line comes from an analog detector, hence the sync
    // No system reset here: the flag must be caught while reset is held
    always_ff @(posedge aclk) begin
        por_s1_r <= power_on_reset;
        por_s2_r <= por_s1_r;
    end

    // Power-on flag survives the system reset; detection beats a clear
    always_ff @(posedge aclk) begin
        if (por_s2_r) pof_r <= 1'b1;
        else if (aresetn && wr_power_control) pof_r <= wbyte_r[POWER_CONTROL_POF];
    end

    // Overflow flags: hardware set wins over service clear and writes
    assign tf1_nxt = timer1_overflow ? 1'b1 :
                     timer1_isr_ack ? 1'b0 :
                     wr_timer_control ? wbyte_r[TIMER_CONTROL_TF1] : tf1_r;
    assign tf0_nxt = timer0_overflow ? 1'b1 :
                     timer0_isr_ack ? 1'b0 :
                     wr_timer_control ? wbyte_r[TIMER_CONTROL_TF0] : tf0_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tf1_r <= 1'b0;
            tf0_r <= 1'b0;
            tr1_r <= 1'b0;
            tr0_r <= 1'b0;
            it1_r <= 1'b0;
            it0_r <= 1'b0;
        end else begin
            tf1_r <= tf1_nxt;
            tf0_r <= tf0_nxt;
            if (wr_timer_control) begin
                tr1_r <= wbyte_r[TIMER_CONTROL_TR1];
                tr0_r <= wbyte_r[TIMER_CONTROL_TR0];
                it1_r <= wbyte_r[TIMER_CONTROL_IT1];
                it0_r <= wbyte_r[TIMER_CONTROL_IT0];
            end
        end
    end

    assign irq1.edge_sel = it1_r;
    assign irq1.sw_we = wr_timer_control;
    assign irq1.sw_val = wbyte_r[TIMER_CONTROL_IE1];
    assign irq1.isr_ack = ext_irq1_isr_ack;
    assign irq0.edge_sel = it0_r;
    assign irq0.sw_we = wr_timer_control;
    assign irq0.sw_val = wbyte_r[TIMER_CONTROL_IE0];
    assign irq0.isr_ack = ext_irq0_isr_ack;

    ext_irq_detect u_irq1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_irq1_pin),
        .irq(irq1)
    );
    ext_irq_detect u_irq0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_irq0_pin),
        .irq(irq0)
    );

    // Any enabled external request can wake from power-down
    wire wake_ext = (ext_irq0_enable & irq0.pending)
                  | (ext_irq1_enable & irq1.pending);
    wire idle_req = wr_power_control & wbyte_r[POWER_CONTROL_IDL];
    wire pd_req = wr_power_control & wbyte_r[POWER_CONTROL_PD];

    power_mode_ctrl u_power (
        .aclk(aclk),
        .aresetn(aresetn),
        .idle_req(idle_req),
        .pd_req(pd_req),
        .wake_any(irq_wake),
        .wake_ext(wake_ext),
        .idle_mode(idle_mode),
        .pd_mode(pd_mode),
        .cpu_clock_enable(cpu_clock_enable),
        .osc_enable(osc_enable)
    );

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign stack_top_pointer = sp_r;
    assign data_pointer = {dph_r, dpl_r};
    assign port4_0_compare_addr = {cah_r, cal_r};
    assign port0_pullup_enable = port_option_r;
    assign baud_doubler = baud_doubler_r;
    assign framing_error_select = framing_error_select_r;
    assign timer1_run = tr1_r;
    assign timer0_run = tr0_r;
    assign timer1_overflow_flag = tf1_r;
    assign timer0_overflow_flag = tf0_r;
    assign ext_irq1_pending = irq1.pending;
    assign ext_irq0_pending = irq0.pending;

    sp_reset_a: assert property (@(posedge aclk)
        !aresetn |=> sp_r == SP_RESET && timer_control_byte == BYTE_RESET)
        else $error("reset values wrong");
    sp_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stack_push && !wr_sp |=> sp_r == 8'($past(sp_r) + 8'h01))
        else $error("push did not advance stack pointer");
    dptr_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_dph |=> data_pointer[15:8] == $past(wbyte_r)
        && data_pointer[7:0] == $past(dpl_r))
        else $error("data pointer high byte wrong");
    rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_hs && ridx == IDX_POWER_CONTROL && raligned |=> !s_axi_rdata[5])
        else $error("reserved power control bit not zero");
    tf1_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        timer1_overflow |=> timer1_overflow_flag)
        else $error("timer 1 overflow lost");
    tf0_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
        timer0_isr_ack && !timer0_overflow |=> !timer0_overflow_flag)
        else $error("timer 0 flag not cleared on service");
    tr_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_timer_control |=> timer1_run == $past(wbyte_r[TIMER_CONTROL_TR1])
        && timer0_run == $past(wbyte_r[TIMER_CONTROL_TR0]))
        else $error("run bits not taken from write");
    pof_set_a: assert property (@(posedge aclk)
        por_s2_r |=> pof_r)
        else $error("power-on flag not set");
    power_control_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_power_control |=> baud_doubler == $past(wbyte_r[POWER_CONTROL_BAUD_DOUBLER])
        && framing_error_select == $past(wbyte_r[POWER_CONTROL_FRAMING_ERROR_SELECT]))
        else $error("serial mode bits not taken");
    resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");
endmodule // core_sfr_low_bank

// file: bench/core_sfr_low_bank_test.sv
// Self-checking bench for the low register bank over AXI4-Lite
module core_sfr_low_bank_test
    import sfr_low_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv, st;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic power_on_reset = 1'h1, ext_irq0_pin = 1'h1, ext_irq1_pin = 1'h1;
    logic ext_irq0_enable = 1'h0, irq_wake = 1'h0, stack_push = 1'h0;
    logic timer0_overflow = 1'h0, timer1_overflow = 1'h0, stack_pop = 1'h0;
    logic timer0_isr_ack = 1'h0, timer1_isr_ack = 1'h0;
    logic ext_irq0_isr_ack = 1'h0, ext_irq1_isr_ack = 1'h0;
    logic [7:0] stack_top_pointer;
    logic [15:0] data_pointer, port4_0_compare_addr;
    logic port0_pullup_enable, baud_doubler, framing_error_select, timer1_run;
    logic timer0_run, timer1_overflow_flag, timer0_overflow_flag;
    logic ext_irq1_pending, ext_irq0_pending, cpu_clock_enable, osc_enable;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    // Status word packs every single-bit non-bus output so one compare covers them all
    assign st = {21'h00_0000, port0_pullup_enable, baud_doubler,
        framing_error_select, timer1_run, timer0_run, timer1_overflow_flag,
        timer0_overflow_flag, ext_irq1_pending, ext_irq0_pending,
        cpu_clock_enable, osc_enable};
    core_sfr_low_bank u_core_sfr_low_bank (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .power_on_reset, .ext_irq0_pin, .ext_irq1_pin, .ext_irq0_enable,
        .ext_irq1_enable(1'h0), .irq_wake, .timer0_overflow, .timer1_overflow,
        .timer0_isr_ack, .timer1_isr_ack, .ext_irq0_isr_ack, .ext_irq1_isr_ack,
        .stack_push, .stack_pop, .stack_top_pointer, .data_pointer,
        .port4_0_compare_addr, .port0_pullup_enable, .baud_doubler,
        .framing_error_select, .timer1_run, .timer0_run, .timer1_overflow_flag,
        .timer0_overflow_flag, .ext_irq1_pending, .ext_irq0_pending,
        .cpu_clock_enable, .osc_enable);
    always #5 aclk = ~aclk;
    task automatic end_sim;
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Generous ceiling; the sequence needs under two hundred cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [IDX_W-1:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        power_on_reset <= 1'h0;
        for (int k = 0; k < 8; k++) begin
            rd(IDX_SP + IDX_W'(k));
            chk(rv, k == 0 ? 32'h7 : k == 6 ? 32'h10 : 32'h0);
        end
        for (int k = 0; k < 5; k++) begin
            wr(IDX_SP + IDX_W'(k), 8'h3C + 8'(k));
            rd(IDX_SP + IDX_W'(k));
            chk(rv, 32'h3C + 32'(k));
        end
        chk({data_pointer, port4_0_compare_addr}, 32'h3E3D_403F);
        stack_push <= 1'h1;
        @(posedge aclk);
        stack_push <= 1'h0;
        @(posedge aclk);
        chk(32'(stack_top_pointer), 32'h3D);
        stack_pop <= 1'h1;
        @(posedge aclk);
        stack_pop <= 1'h0;
        @(posedge aclk);
        chk(32'(stack_top_pointer), 32'h3C);
        wr(IDX_PORT_OPTION, 8'hFF);
        rd(IDX_PORT_OPTION);
        chk(rv, 32'h1);
        wr(IDX_POWER_CONTROL, 8'hEC);
        rd(IDX_POWER_CONTROL);
        chk(rv, 32'hCC);
        wr(IDX_TIMER_CONTROL, 8'h50);
        chk(st, 32'h7C3);
        timer0_overflow <= 1'h1;
        timer1_overflow <= 1'h1;
        @(posedge aclk);
        timer0_overflow <= 1'h0;
        timer1_overflow <= 1'h0;
        rd(IDX_TIMER_CONTROL);
        chk(rv, 32'hF0);
        timer0_isr_ack <= 1'h1;
        timer1_isr_ack <= 1'h1;
        @(posedge aclk);
        timer0_isr_ack <= 1'h0;
        timer1_isr_ack <= 1'h0;
        @(posedge aclk);
        chk(st, 32'h7C3);
        wr(IDX_TIMER_CONTROL, 8'h05);
        ext_irq0_pin <= 1'h0;
        ext_irq1_pin <= 1'h0;
        repeat (6) @(posedge aclk);
        ext_irq0_pin <= 1'h1;
        ext_irq1_pin <= 1'h1;
        repeat (6) @(posedge aclk);
        chk(st, 32'h70F);
        ext_irq0_isr_ack <= 1'h1;
        ext_irq1_isr_ack <= 1'h1;
        @(posedge aclk);
        ext_irq0_isr_ack <= 1'h0;
        ext_irq1_isr_ack <= 1'h0;
        @(posedge aclk);
        chk(st, 32'h703);
        wr(IDX_TIMER_CONTROL, 8'h00);
        ext_irq1_pin <= 1'h0;
        repeat (6) @(posedge aclk);
        chk(st, 32'h70B);
        ext_irq1_pin <= 1'h1;
        repeat (6) @(posedge aclk);
        chk(st, 32'h703);
        wr(IDX_POWER_CONTROL, 8'h01);
        repeat (2) @(posedge aclk);
        chk(st, 32'h401);
        irq_wake <= 1'h1;
        @(posedge aclk);
        irq_wake <= 1'h0;
        repeat (2) @(posedge aclk);
        chk(st, 32'h403);
        wr(IDX_TIMER_CONTROL, 8'h01);
        ext_irq0_enable <= 1'h1;
        wr(IDX_POWER_CONTROL, 8'h02);
        repeat (2) @(posedge aclk);
        chk(st, 32'h400);
        ext_irq0_pin <= 1'h0;
        repeat (8) @(posedge aclk);
        chk(st, 32'h407);
        rd(10'h089);
        chk({rs, rv[29:0]}, 32'h8000_0000);
        aresetn <= 1'h0;
        @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk(32'(stack_top_pointer), 32'h7);
        end_sim();
    end
endmodule // core_sfr_low_bank_test
